// ===== hdl/dio_channels.sv
// Purpose: digital i/o channels, button reset timing, modem line events
// Assumes: APB slave with one wait state; pins are asynchronous
// Notes: password erase and factory load are pulses to firmware
`timescale 1ns/100ps
module io_channels #(
  parameter int unsigned N_CH = 4,
  parameter int unsigned ERASE_CYC = chan_pkg::ERASE_HOLD_CYC,
  parameter int unsigned FACTORY_CYC = chan_pkg::FACTORY_HOLD_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins
  input wire logic [N_CH-1:0] pin_in,
  output logic [N_CH-1:0] pin_out,
  output logic [N_CH-1:0] pin_oe,
  // modem lines
  input wire logic dcd_in,
  input wire logic dsr_in,
  // events
  output logic erase_pw_pulse,
  output logic factory_pulse,
  output logic line_change_pulse,
  output logic irq
);
  import chan_pkg::*;

  initial begin
    if (N_CH < 1 || N_CH > 32) $error("N_CH must be 1..32");
    if (ERASE_CYC < 1 || FACTORY_CYC <= ERASE_CYC) $error("bad hold counts");
    if (FACTORY_CYC >= (1 << HOLD_CNT_W)) $error("hold count too wide");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HELD = 3'b010,
    ST_DONE = 3'b100
  } btn_st_t;

  function automatic logic [31:0] pad(input logic [N_CH-1:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[N_CH-1:0] = v;
    return r;
  endfunction

  // synchronisers
  logic [N_CH-1:0] din_s1_ff, din_s2_ff;
  logic [1:0] ln_s1_ff, ln_s2_ff, ln_prev_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      din_s1_ff <= '1;
      din_s2_ff <= '1;
      ln_s1_ff <= 2'h0;
      ln_s2_ff <= 2'h0;
      ln_prev_ff <= 2'h0;
    end else begin
      din_s1_ff <= pin_in;
      din_s2_ff <= din_s1_ff;
      ln_s1_ff <= {dsr_in, dcd_in};
      ln_s2_ff <= ln_s1_ff;
      ln_prev_ff <= ln_s2_ff;
    end
  end

  // registers
  logic [N_CH-1:0] mode_ff, nxt_mode;
  logic [N_CH-1:0] level_ff, nxt_level;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [IRQ_W-1:0] stat_ff, nxt_stat;
  logic [IRQ_W-1:0] mask_ff, nxt_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [N_CH-1:0] out_ff, nxt_out, oe_ff, nxt_oe;
  logic irq_ff, nxt_irq;
  logic line_ff, nxt_line;
  // button state
  btn_st_t st_ff, nxt_st;
  logic [HOLD_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic erase_ff, nxt_erase, fact_ff, nxt_fact;
  logic [IRQ_W-1:0] ev;
  logic access, wr, btn_en, ch1_low;

  assign access = psel && penable && !pready_ff;
  assign wr = access && pwrite;
  assign btn_en = ctrl_ff[CTRL_BTN_EN];
  assign ch1_low = btn_en && !din_s2_ff[0];

  // button reset timing
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_erase = 1'b0;
    nxt_fact = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        nxt_cnt = '0;
        if (ch1_low) begin
          nxt_st = ST_HELD;
          nxt_cnt = HOLD_CNT_W'(1);
        end
      end
      ST_HELD: begin
        if (!ch1_low) begin
          nxt_st = ST_IDLE;
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + HOLD_CNT_W'(1);
          if (cnt_ff == HOLD_CNT_W'(ERASE_CYC - 1)) nxt_erase = 1'b1;
          if (cnt_ff == HOLD_CNT_W'(FACTORY_CYC - 1)) begin
            nxt_fact = 1'b1;
            nxt_st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        nxt_cnt = '0;
        if (!ch1_low) nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  // events
  always_comb begin
    ev = '0;
    if (ctrl_ff[CTRL_RS232]) begin
      ev[IRQ_DCD_UP] = ln_s2_ff[0] && !ln_prev_ff[0];
      ev[IRQ_DCD_DN] = !ln_s2_ff[0] && ln_prev_ff[0];
      ev[IRQ_DSR_UP] = ln_s2_ff[1] && !ln_prev_ff[1];
      ev[IRQ_DSR_DN] = !ln_s2_ff[1] && ln_prev_ff[1];
    end
    ev[IRQ_ERASE] = erase_ff;
    ev[IRQ_FACTORY] = fact_ff;
  end

  // register file and pin drive
  always_comb begin
    nxt_mode = mode_ff;
    nxt_level = level_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_pready = access;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (access) begin
      case (paddr)
        OFS_MODE: begin
          nxt_prdata = pad(mode_ff);
          if (wr) nxt_mode = pwdata[N_CH-1:0];
        end
        OFS_LEVEL: begin
          nxt_prdata = pad(level_ff);
          if (wr) nxt_level = pwdata[N_CH-1:0];
        end
        OFS_INPUT: nxt_prdata = pad(din_s2_ff);
        OFS_CTRL: begin
          nxt_prdata = {30'h0000_0000, ctrl_ff};
          if (wr) nxt_ctrl = pwdata[1:0];
        end
        OFS_IRQ_STAT: begin
          nxt_prdata = {26'h000_0000, stat_ff};
          if (wr) nxt_stat = stat_ff & ~pwdata[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          nxt_prdata = {26'h000_0000, mask_ff};
          if (wr) nxt_mask = pwdata[IRQ_W-1:0];
        end
        OFS_LINE: nxt_prdata = {30'h0000_0000, ln_s2_ff};
        default: nxt_pslverr = 1'b1;
      endcase
    end
    // set wins over a clear in the same cycle
    nxt_stat = nxt_stat | ev;
    if (fact_ff) nxt_ctrl[CTRL_BTN_EN] = 1'b0;
    nxt_irq = |(nxt_stat & nxt_mask);
    nxt_line = |ev[IRQ_DSR_DN:IRQ_DCD_UP];
    nxt_oe = mode_ff;
    if (nxt_ctrl[CTRL_BTN_EN]) nxt_oe[0] = 1'b0;
    nxt_out = level_ff & nxt_oe;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_ff <= '0;
      level_ff <= '0;
      ctrl_ff <= RST_CTRL;
      stat_ff <= '0;
      mask_ff <= '0;
      prdata_ff <= RST_WORD;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      out_ff <= '0;
      oe_ff <= '0;
      irq_ff <= 1'b0;
      line_ff <= 1'b0;
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      erase_ff <= 1'b0;
      fact_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      level_ff <= nxt_level;
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      irq_ff <= nxt_irq;
      line_ff <= nxt_line;
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      erase_ff <= nxt_erase;
      fact_ff <= nxt_fact;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign irq = irq_ff;
  assign line_change_pulse = line_ff;
  assign erase_pw_pulse = erase_ff;
  assign factory_pulse = fact_ff;

  // checks
  sequence s_dcd_rise;
    ln_s2_ff[0] && !ln_prev_ff[0] && ctrl_ff[CTRL_RS232];
  endsequence
  sequence s_dsr_rise;
    ln_s2_ff[1] && !ln_prev_ff[1] && ctrl_ff[CTRL_RS232];
  endsequence
  property p_oe_mode;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 (oe_ff[N_CH-1:1] == $past(mode_ff[N_CH-1:1]));
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("oe not following mode");
  property p_out_level;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 (out_ff == ($past(level_ff) & oe_ff));
  endproperty
  a_out_level: assert property (p_out_level) else $error("out not level");
  property p_in_quiet;
    @(posedge ref_clk) disable iff (!rst_n) ((pin_out & ~pin_oe) == '0);
  endproperty
  a_in_quiet: assert property (p_in_quiet) else $error("input channel driven");
  property p_btn_input;
    @(posedge ref_clk) disable iff (!rst_n) ctrl_ff[CTRL_BTN_EN] |-> !oe_ff[0];
  endproperty
  a_btn_input: assert property (p_btn_input) else $error("ch1 not input");
  property p_erase;
    @(posedge ref_clk) disable iff (!rst_n)
      erase_pw_pulse |-> ($past(cnt_ff) == HOLD_CNT_W'(ERASE_CYC - 1));
  endproperty
  a_erase: assert property (p_erase) else $error("erase at wrong count");
  property p_factory;
    @(posedge ref_clk) disable iff (!rst_n)
      factory_pulse |-> ($past(cnt_ff) == HOLD_CNT_W'(FACTORY_CYC - 1));
  endproperty
  a_factory: assert property (p_factory) else $error("factory at wrong count");
  property p_fact_off;
    @(posedge ref_clk) disable iff (!rst_n) factory_pulse |=> !ctrl_ff[CTRL_BTN_EN];
  endproperty
  a_fact_off: assert property (p_fact_off) else $error("button reset kept");
  property p_dcd_up;
    @(posedge ref_clk) disable iff (!rst_n)
      s_dcd_rise |=> (stat_ff[IRQ_DCD_UP] && line_change_pulse);
  endproperty
  a_dcd_up: assert property (p_dcd_up) else $error("dcd rise lost");
  property p_dsr_up;
    @(posedge ref_clk) disable iff (!rst_n)
      s_dsr_rise |=> (stat_ff[IRQ_DSR_UP] && line_change_pulse);
  endproperty
  a_dsr_up: assert property (p_dsr_up) else $error("dsr rise lost");
  property p_no_rs485;
    @(posedge ref_clk) disable iff (!rst_n)
      !ctrl_ff[CTRL_RS232] |=> !line_change_pulse;
  endproperty
  a_no_rs485: assert property (p_no_rs485) else $error("line event off rs232");
  property p_restart;
    @(posedge ref_clk) disable iff (!rst_n) !ch1_low |=> (cnt_ff == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted");
endmodule

// ===== hdl/dio_pkg.sv
// Purpose: shared constants for the digital i/o channel block
// Assumes: 20 MHz ref_clk, 32-bit APB register access
// Notes: offsets are byte addresses of aligned words
package chan_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned ERASE_HOLD_S = 3;
  localparam int unsigned FACTORY_HOLD_S = 10;
  localparam int unsigned ERASE_HOLD_CYC = ERASE_HOLD_S * CLK_HZ;
  localparam int unsigned FACTORY_HOLD_CYC = FACTORY_HOLD_S * CLK_HZ;
  localparam int unsigned HOLD_CNT_W = 28;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_INPUT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_LINE = 8'h18;
  // ctrl fields
  localparam int unsigned CTRL_BTN_EN = 0;
  localparam int unsigned CTRL_RS232 = 1;
  // irq status fields
  localparam int unsigned IRQ_DCD_UP = 0;
  localparam int unsigned IRQ_DCD_DN = 1;
  localparam int unsigned IRQ_DSR_UP = 2;
  localparam int unsigned IRQ_DSR_DN = 3;
  localparam int unsigned IRQ_ERASE = 4;
  localparam int unsigned IRQ_FACTORY = 5;
  localparam int unsigned IRQ_W = 6;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_CTRL = 2'h2;
endpackage

// ===== tb/dio_far_side.sv
// Purpose: switches, loads and modem lines beside the channel pins
// Assumes: switch and modem levels are set by the bench
// Notes: a driven pin shows the block's level, an undriven one its switch
`timescale 1ns/100ps
module chan_far_side (
  // from bench
  input wire logic [3:0] sw_lvl,
  input wire logic dcd_lvl,
  input wire logic dsr_lvl,
  // block pins
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in,
  output logic dcd_in,
  output logic dsr_in
);
  // the block's driver overrides the switch pull
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw_lvl);
  assign dcd_in = dcd_lvl;
  assign dsr_in = dsr_lvl;
endmodule

// ===== tb/test_dio_channels_reset_and_line_events.sv
// Purpose: self-checking bench for the channel block
// Assumes: short hold counts stand in for the long button times
// Notes: register traffic goes over APB
`timescale 1ns/100ps
module test_dio_channels_reset_and_line_events;
  import chan_pkg::*;
  localparam int ER = 20;
  localparam int FA = 50;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pin_in, pin_out, pin_oe, sw, md, lv;
  logic dcd, dsr, dcd_in, dsr_in, erase_pw_pulse, factory_pulse, line_change_pulse, irq;
  int err_total = 0;
  int num_checks = 0;
  int n_er = 0;
  int n_fa = 0;
  int n_lc = 0;
  io_channels #(.N_CH(4), .ERASE_CYC(ER), .FACTORY_CYC(FA)) DUT (.ref_clk(ref_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .dcd_in(dcd_in), .dsr_in(dsr_in),
    .erase_pw_pulse(erase_pw_pulse), .factory_pulse(factory_pulse),
    .line_change_pulse(line_change_pulse), .irq(irq));
  chan_far_side far (.sw_lvl(sw), .dcd_lvl(dcd), .dsr_lvl(dsr), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in), .dcd_in(dcd_in), .dsr_in(dsr_in));
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (erase_pw_pulse === 1'b1) n_er++;
    if (factory_pulse === 1'b1) n_fa++;
    if (line_change_pulse === 1'b1) n_lc++;
  end
  task results;
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // levels read back: driven channels show their level, the rest their switch
  function automatic logic [31:0] exp_pins(input logic [3:0] m, input logic [3:0] l,
    input logic [3:0] s);
    return {28'h0, (m & l) | (~m & s)};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one idle edge first, so psel never changes twice in a time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 1, 0);
      results;
    end
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(0, a, 0);
    chk(nm, e, q);
  endtask
  task hold(input int n);
    sw[0] <= 0;
    cyc(n);
    sw[0] <= 1;
    cyc(8);
  endtask
  initial begin
    rst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    sw = 4'hf;
    dcd = 0;
    dsr = 0;
    void'($urandom(32'h4ff1));
    cyc(6);
    rst_n <= 1;
    rd(OFS_MODE, 0, "mode");
    rd(OFS_LEVEL, 0, "level");
    rd(OFS_CTRL, 32'h0000_0002, "ctrl");
    rd(OFS_IRQ_STAT, 0, "stat");
    chk("slverr ok", 0, {31'h0, se});
    rd(8'h1c, 0, "unmapped");
    chk("slverr", 1, {31'h0, se});
    for (int i = 0; i < 8; i++) begin
      md = (i < 2) ? {4{i[0]}} : 4'($urandom);
      lv = 4'($urandom);
      sw <= 4'($urandom);
      apb(1, OFS_MODE, {28'h0, md});
      apb(1, OFS_LEVEL, {28'h0, lv});
      cyc(4);
      chk("oe", {28'h0, md}, {28'h0, pin_oe});
      chk("out", {28'h0, md & lv}, {28'h0, pin_out});
      rd(OFS_INPUT, exp_pins(md, lv, sw), "input");
    end
    sw <= 4'hf;
    apb(1, OFS_MODE, 32'h0000_0001);
    apb(1, OFS_IRQ_MASK, 32'h0000_003f);
    apb(1, OFS_CTRL, 32'h0000_0003);
    cyc(3);
    chk("oe0 forced", 0, {31'h0, pin_oe[0]});
    hold(ER - 4);
    hold(ER - 4);
    chk("short holds", 0, n_er);
    hold(ER + 6);
    chk("erase", 1, n_er);
    chk("no factory", 0, n_fa);
    rd(OFS_IRQ_STAT, 32'h0000_0010, "stat erase");
    apb(1, OFS_IRQ_STAT, 32'h0000_003f);
    hold(FA + 6);
    chk("factory", 1, n_fa);
    rd(OFS_IRQ_STAT, 32'h0000_0030, "stat factory");
    rd(OFS_CTRL, 32'h0000_0002, "ctrl after");
    cyc(3);
    chk("oe0 free", 1, {31'h0, pin_oe[0]});
    apb(1, OFS_IRQ_STAT, 32'h0000_003f);
    for (int k = 0; k < 4; k++) begin
      if (k < 2) dcd <= ~dcd;
      else dsr <= ~dsr;
      cyc(6);
      chk("irq", 1, {31'h0, irq});
      rd(OFS_IRQ_STAT, 32'h0000_0001 << k, "line stat");
      rd(OFS_LINE, {30'h0, dsr, dcd}, "line");
      apb(1, OFS_IRQ_STAT, 32'h0000_003f);
      cyc(2);
      chk("irq clear", 0, {31'h0, irq});
    end
    chk("changes", 4, n_lc);
    apb(1, OFS_IRQ_MASK, 0);
    dcd <= 1;
    cyc(6);
    chk("irq masked", 0, {31'h0, irq});
    rd(OFS_IRQ_STAT, 32'h0000_0001, "masked stat");
    apb(1, OFS_CTRL, 0);
    apb(1, OFS_IRQ_STAT, 32'h0000_003f);
    dcd <= 0;
    dsr <= 1;
    cyc(6);
    rd(OFS_IRQ_STAT, 0, "no rs232 stat");
    chk("no rs232 change", 5, n_lc);
    results;
  end
endmodule
